//--- gdio_pad_model.sv
// Pad-side circuitry: external drivers, pull-up resolution and floating pins
`timescale 1ns/1ps
module gdio_pad_model
  import gdio_pkg::*;
(
  input wire logic mclk, // System clock, paces the floating pattern
  input wire logic [gdio_pkg::PIN_COUNT-1:0] pad_out, // Level driven by the port
  input wire logic [gdio_pkg::PIN_COUNT-1:0] pad_oe, // Port driver enable
  input wire logic [gdio_pkg::PIN_COUNT-1:0] pad_pullup, // Port pull-up enable
  input wire logic [gdio_pkg::PIN_COUNT-1:0] ext_en, // External driver enable
  input wire logic [gdio_pkg::PIN_COUNT-1:0] ext_val, // External driver level
  output logic [gdio_pkg::PIN_COUNT-1:0] pad_in // Resolved pad level
);
  logic [PIN_COUNT-1:0] float_pat = 8'h5A;
  // Undriven pins without pull-up toggle on each rising clock edge, so a floating read matches a fixed value only on alternate cycles
  always @(posedge mclk) float_pat <= ~float_pat;
  assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_en & ext_val) |
                  (~pad_oe & ~ext_en & (pad_pullup | float_pat));
endmodule : gdio_pad_model

//--- gdio_pkg.sv
// Constants for the general digital I/O port: register map, fields, reset values, bus codes
package gdio_pkg;
  localparam int PIN_COUNT = 8;
  localparam int AXI_ADDR_W = 8;
  localparam int AXI_DATA_W = 32;
  localparam int AXI_STRB_W = 4;
  // Register byte offsets
  localparam logic [AXI_ADDR_W-1:0] OFS_PORT_IN = 8'h00;
  localparam logic [AXI_ADDR_W-1:0] OFS_PORT_DIR = 8'h04;
  localparam logic [AXI_ADDR_W-1:0] OFS_PORT_OUT_VAL = 8'h08;
  localparam logic [AXI_ADDR_W-1:0] OFS_MCU_CTRL = 8'h0C;
  // Field positions
  localparam int PULLUP_OFF_BIT = 0;
  localparam int BYTE0_STRB = 0;
  // Reset values
  localparam logic [PIN_COUNT-1:0] RST_PORT_DIR = 8'h00;
  localparam logic [PIN_COUNT-1:0] RST_PORT_OUT_VAL = 8'h00;
  localparam logic RST_PULLUP_OFF = 1'b0;
  // Response codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Register selector
  typedef enum logic [2:0] {
    GDIO_SEL_IN,
    GDIO_SEL_DIR,
    GDIO_SEL_OUT,
    GDIO_SEL_CTRL,
    GDIO_SEL_NONE
  } gdio_sel_t;
  // Answer latency of the bus slave, in clock cycles after both write halves are taken
  localparam int WR_RESP_CYCLES = 1;
endpackage : gdio_pkg

//--- gdio_port.sv
// One eight-pin general digital I/O port with an AXI4-Lite register slave
//
// Chosen here: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
// How it works
// RQ1: Direction bit one drives the pad; zero leaves the pin as input.
// RQ2: Input pin with output-value one gets pull-up unless pull-ups globally disabled.
// RQ3: Pull-up is off when output-value is zero or pin is an output.
// RQ4: Reset asynchronously tri-states all pins, no clock needed.
// RQ5: Output pin drives pad high for value one, low for zero.
// RQ6: Writing one to pin-input register toggles output-value bit; zero does nothing.
// RQ7: Global pull-up disable set keeps input pin with value one floating.
// RQ8: Software passes via pull-up input or output low between tri-state and high.
// RQ9: Software passes via tri-state or output high between pull-up and low.
// RQ10: Pad level is readable in pin-input register whatever the direction.
// RQ11: Input latched on clock fall, captured into pin-input register on rise.
// RQ12: Pad change appears in pin-input register after half to one-and-half periods.
// RQ13: Software-driven pin value reaches pin-input register one period after write.
// RQ14: Software inserts one idle cycle between pin write and read-back.
// RQ15: Deep sleep clamps each digital input to ground before the synchroniser.
// RQ16: Clamp is bypassed for pins whose external interrupt is enabled.
// RQ17: Clamped high pin shows a rising change on wake for interrupt logic.
// RQ18: Strobes shared by port pins; clock, sleep and pull-up disable shared.
// RQ19: Pin-input register stores nothing; direction and value registers read/write.
// RQ20: Pad controls come from registered bits without added latency.
// RQ21: Direction and output-value reset to zero: input, no pull-up.
module gdio_port
  import gdio_pkg::*;
(
  input wire logic mclk, // System clock, 25 MHz
  input wire logic resetn, // Asynchronous reset, active low
  input wire logic [gdio_pkg::AXI_ADDR_W-1:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [gdio_pkg::AXI_DATA_W-1:0] s_axi_wdata, // Write data
  input wire logic [gdio_pkg::AXI_STRB_W-1:0] s_axi_wstrb, // Write byte strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [gdio_pkg::AXI_ADDR_W-1:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [gdio_pkg::AXI_DATA_W-1:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  input wire logic [gdio_pkg::PIN_COUNT-1:0] pad_in, // Pad level seen at each pin
  output logic [gdio_pkg::PIN_COUNT-1:0] pad_out, // Level driven onto each pad
  output logic [gdio_pkg::PIN_COUNT-1:0] pad_oe, // Pad driver enable, high drives
  output logic [gdio_pkg::PIN_COUNT-1:0] pad_pullup, // Internal pull-up enable
  input wire logic sleep_clamp, // Deep sleep clamp request, shared by all ports
  input wire logic [gdio_pkg::PIN_COUNT-1:0] ext_int_en, // External interrupt enabled per pin
  output logic global_pullup_off // Pull-up disable, fanned out to other ports
);
  import gdio_pkg::*;

  logic [PIN_COUNT-1:0] port_dir_reg;
  logic [PIN_COUNT-1:0] port_out_val_reg;
  logic [PIN_COUNT-1:0] port_in_reg;
  logic [PIN_COUNT-1:0] sync_latch;
  logic [PIN_COUNT-1:0] pin_di;
  logic [AXI_ADDR_W-1:0] wr_addr;
  logic [AXI_DATA_W-1:0] wr_data;
  logic [AXI_STRB_W-1:0] wr_strb;
  logic do_wr;
  gdio_sel_t wr_sel;
  logic [PIN_COUNT-1:0] next_dir;
  logic [PIN_COUNT-1:0] next_out;
  logic next_pullup_off;

  function automatic gdio_sel_t decode_sel(input logic [AXI_ADDR_W-1:0] addr);
    gdio_sel_t sel;
    sel = GDIO_SEL_NONE;
    if (addr == OFS_PORT_IN) begin
      sel = GDIO_SEL_IN;
    end else if (addr == OFS_PORT_DIR) begin
      sel = GDIO_SEL_DIR;
    end else if (addr == OFS_PORT_OUT_VAL) begin
      sel = GDIO_SEL_OUT;
    end else if (addr == OFS_MCU_CTRL) begin
      sel = GDIO_SEL_CTRL;
    end
    return sel;
  endfunction : decode_sel

  // Write channel: address and data taken in either order, one write in flight
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      s_axi_awready <= 1'b1;
      wr_addr <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      s_axi_awready <= 1'b0;
      wr_addr <= s_axi_awaddr;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      s_axi_wready <= 1'b1;
      wr_data <= 32'h00000000;
      wr_strb <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      s_axi_wready <= 1'b0;
      wr_data <= s_axi_wdata;
      wr_strb <= s_axi_wstrb;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_wready <= 1'b1;
    end
  end

  assign do_wr = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  assign wr_sel = decode_sel(wr_addr);

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (do_wr) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (wr_sel == GDIO_SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Register update; the per-port strobes are the decoded write selects
  always_comb begin
    next_dir = port_dir_reg;
    next_out = port_out_val_reg;
    next_pullup_off = global_pullup_off;
    if (do_wr && wr_strb[BYTE0_STRB]) begin
      unique case (wr_sel)
        GDIO_SEL_IN: next_out = port_out_val_reg ^ wr_data[PIN_COUNT-1:0]; // [RQ6] [RQ18]
        GDIO_SEL_DIR: next_dir = wr_data[PIN_COUNT-1:0]; // [RQ19]
        GDIO_SEL_OUT: next_out = wr_data[PIN_COUNT-1:0]; // [RQ19]
        GDIO_SEL_CTRL: next_pullup_off = wr_data[PULLUP_OFF_BIT];
        GDIO_SEL_NONE: next_pullup_off = global_pullup_off;
      endcase
    end
  end

  // Pad controls register alongside the bits so no cycle is added
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      port_dir_reg <= RST_PORT_DIR; // [RQ21]
      port_out_val_reg <= RST_PORT_OUT_VAL; // [RQ21]
      global_pullup_off <= RST_PULLUP_OFF;
      pad_oe <= RST_PORT_DIR; // [RQ4]
      pad_out <= RST_PORT_OUT_VAL;
      pad_pullup <= {PIN_COUNT{1'b0}}; // [RQ4]
    end else begin
      port_dir_reg <= next_dir;
      port_out_val_reg <= next_out;
      global_pullup_off <= next_pullup_off; // [RQ18]
      pad_oe <= next_dir; // [RQ1] [RQ20]
      pad_out <= next_out; // [RQ5] [RQ20]
      pad_pullup <= ~next_dir & next_out & {PIN_COUNT{~next_pullup_off}}; // [RQ2] [RQ3] [RQ7] [RQ20]
    end
  end

  // Sleep clamp ahead of the synchroniser, bypassed for interrupt pins
  assign pin_di = pad_in & ~({PIN_COUNT{sleep_clamp}} & ~ext_int_en); // [RQ15] [RQ16]

  // Falling-edge stage stands in for the latch that closes while the clock is low
  always_ff @(negedge mclk or negedge resetn) begin
    if (!resetn) begin
      sync_latch <= {PIN_COUNT{1'b0}};
    end else begin
      sync_latch <= pin_di; // [RQ11] [RQ12]
    end
  end

  // Rising-edge capture; a clamped-high pin rises here on wake
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      port_in_reg <= {PIN_COUNT{1'b0}};
    end else begin
      port_in_reg <= sync_latch; // [RQ10] [RQ11] [RQ13] [RQ17]
    end
  end

  // Read channel: one read in flight, data registered with the answer
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= RESP_OKAY;
      unique case (decode_sel(s_axi_araddr))
        GDIO_SEL_IN: s_axi_rdata <= {24'h000000, port_in_reg}; // [RQ10] [RQ19]
        GDIO_SEL_DIR: s_axi_rdata <= {24'h000000, port_dir_reg}; // [RQ19]
        GDIO_SEL_OUT: s_axi_rdata <= {24'h000000, port_out_val_reg}; // [RQ19]
        GDIO_SEL_CTRL: s_axi_rdata <= {31'h00000000, global_pullup_off};
        GDIO_SEL_NONE: begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  default clocking gdio_cb @(posedge mclk);
  endclocking
  default disable iff (!resetn);

  AST_RESET_HIZ: assert property (@(posedge mclk) disable iff (1'b0) // [RQ4]
    !resetn |-> (pad_oe == 8'h00) && (pad_pullup == 8'h00))
    else $error("Pins not tri-stated during reset");

  AST_DRIVE_FOLLOWS_REGS: assert property ( // [RQ1]
    (pad_oe == port_dir_reg) && (pad_out == port_out_val_reg))
    else $error("Pad driver does not match direction and value bits");

  AST_PULLUP_TABLE: assert property ( // [RQ2]
    pad_pullup == (~port_dir_reg & port_out_val_reg & {PIN_COUNT{~global_pullup_off}}))
    else $error("Pull-up enable disagrees with direction, value and disable");

  AST_PUD_KILLS_PULLUP: assert property ( // [RQ7]
    global_pullup_off |-> (pad_pullup == 8'h00))
    else $error("Pull-up active while globally disabled");

  AST_TOGGLE_WRITE: assert property ( // [RQ6]
    (do_wr && wr_strb[BYTE0_STRB] && wr_sel == GDIO_SEL_IN)
      |=> port_out_val_reg == ($past(port_out_val_reg) ^ $past(wr_data[PIN_COUNT-1:0])))
    else $error("Pin-input write did not toggle output values");

  AST_DIR_WRITE: assert property ( // [RQ19]
    (do_wr && wr_strb[BYTE0_STRB] && wr_sel == GDIO_SEL_DIR)
      |=> (port_dir_reg == $past(wr_data[PIN_COUNT-1:0])) && $stable(port_out_val_reg))
    else $error("Direction write not stored");

  AST_SYNC_DELAY: assert property ( // [RQ11]
    ##1 port_in_reg == $past(sync_latch))
    else $error("Pin-input register not loaded from falling-edge stage");

  AST_SLEEP_CLAMP: assert property ( // [RQ15]
    sleep_clamp |=> (port_in_reg & ~$past(ext_int_en)) == 8'h00)
    else $error("Clamped inputs read nonzero during sleep");

  AST_WRITE_ANSWER: assert property ( // [RQ19]
    (s_axi_awvalid && s_axi_awready ##[0:4] s_axi_wvalid && s_axi_wready)
      |-> ##[1:2] s_axi_bvalid)
    else $error("Write response missing after both halves taken");

  // Register effects of a write land at the edge that raises the answer
  AST_OUT_WRITE: assert property ( // [RQ5]
    (do_wr && wr_strb[BYTE0_STRB] && wr_sel == GDIO_SEL_OUT)
      |=> (pad_out == $past(wr_data[PIN_COUNT-1:0])) && $stable(port_dir_reg))
    else $error("Output-value write not driven onto pads");

  AST_CTRL_WRITE: assert property ( // [RQ7]
    (do_wr && wr_strb[BYTE0_STRB] && wr_sel == GDIO_SEL_CTRL)
      |=> global_pullup_off == $past(wr_data[PULLUP_OFF_BIT]))
    else $error("Pull-up disable write not stored");

  AST_IDLE_HOLDS: assert property ( // [RQ19]
    !(do_wr && wr_strb[BYTE0_STRB])
      |=> $stable(port_dir_reg) && $stable(port_out_val_reg) && $stable(global_pullup_off))
    else $error("Register bits changed without a write");

  AST_PULLUP_OFF_DRIVEN: assert property ( // [RQ3]
    ((pad_oe | ~pad_out) & pad_pullup) == 8'h00)
    else $error("Pull-up enabled on an output or a zero-valued pin");

  AST_UNMAPPED_WRITE: assert property (
    (do_wr && wr_sel == GDIO_SEL_NONE)
      |=> s_axi_bvalid && (s_axi_bresp == RESP_SLVERR) && $stable(port_dir_reg))
    else $error("Unmapped write not refused");

  // Bus handshake checks
  AST_WRITE_BLOCKED: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("Write channel open while a response is pending");

  AST_WRITE_RELEASE: assert property (
    (s_axi_bvalid && s_axi_bready) |=> !s_axi_bvalid && s_axi_awready && s_axi_wready)
    else $error("Write channel not released after the response");

  AST_READ_ANSWER: assert property ( // [RQ19]
    (s_axi_arvalid && s_axi_arready) |=> s_axi_rvalid && !s_axi_arready)
    else $error("Read data missing one cycle after the address");

  AST_READ_PIN: assert property ( // [RQ10]
    (s_axi_arvalid && s_axi_arready && decode_sel(s_axi_araddr) == GDIO_SEL_IN)
      |=> s_axi_rdata == {24'h000000, $past(port_in_reg)})
    else $error("Pin-input read does not return the synchronised pad level");

  AST_READ_RELEASE: assert property (
    (s_axi_rvalid && s_axi_rready) |=> !s_axi_rvalid && s_axi_arready)
    else $error("Read channel not released after the data");

  AST_UNMAPPED_READ: assert property (
    (s_axi_arvalid && s_axi_arready && decode_sel(s_axi_araddr) == GDIO_SEL_NONE)
      |=> (s_axi_rresp == RESP_SLVERR) && (s_axi_rdata == 32'h00000000))
    else $error("Unmapped read not refused");

endmodule : gdio_port

//--- general_digital_io_port_pin_tb.sv
// Self-checking bench for the general digital I/O port
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin bad_count++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module general_digital_io_port_pin_tb;
  import gdio_pkg::*;
  logic mclk = 0, resetn = 1'h1, sleep_clamp = 0;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0, pad_in, pad_out, pad_oe, pad_pullup;
  logic [7:0] ext_int_en = 0, ext_en = 8'h03, ext_val = 8'h01;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, global_pullup_off;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  int bad_count = 0, check_count = 0;
  always #20 mclk = ~mclk;
  gdio_port u_dut (.mclk, .resetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pad_in, .pad_out, .pad_oe, .pad_pullup,
    .sleep_clamp, .ext_int_en, .global_pullup_off);
  gdio_pad_model u_pad (.mclk, .pad_out, .pad_oe, .pad_pullup, .ext_en, .ext_val, .pad_in);
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF);
    bit aw, w;
    aw = 0;
    w = 0;
    @(posedge mclk);
    s_axi_awaddr <= a; s_axi_awvalid <= 1; s_axi_wdata <= d; s_axi_wstrb <= s;
    s_axi_wvalid <= 1; s_axi_bready <= 1;
    do begin
      @(posedge mclk);
      if (!aw && s_axi_awready === 1'b1) begin aw = 1; s_axi_awvalid <= 0; end
      if (!w && s_axi_wready === 1'b1) begin w = 1; s_axi_wvalid <= 0; end
    end while (!(aw && w));
    do @(posedge mclk); while (s_axi_bvalid !== 1'b1);
    rs = s_axi_bresp;
    s_axi_bready <= 0;
  endtask : wr
  task automatic rdr(input logic [7:0] a);
    @(posedge mclk);
    s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
    do @(posedge mclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 0;
    do @(posedge mclk); while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata; rs = s_axi_rresp;
    s_axi_rready <= 0;
  endtask : rdr
  task automatic wrap_up();
    $display("checks=%0d mismatches=%0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : wrap_up
  initial begin
    #200us;
    bad_count++;
    wrap_up();
  end
  initial begin
    resetn <= 1'h0; // Falling edge at time zero resets with no clock
    repeat (5) @(posedge mclk);
    resetn <= 1;
    `CHK(pad_oe | pad_pullup, 8'h00)
    rdr(OFS_PORT_DIR); `CHK(rd, {24'h0, RST_PORT_DIR})
    rdr(OFS_PORT_OUT_VAL); `CHK(rd, {24'h0, RST_PORT_OUT_VAL})
    wr(OFS_PORT_OUT_VAL, 32'hF0); `CHK(pad_pullup, 8'hF0)
    wr(OFS_MCU_CTRL, 32'h1); `CHK({global_pullup_off, pad_pullup}, 9'h100)
    rdr(OFS_MCU_CTRL); `CHK(rd, 32'h1)
    wr(OFS_MCU_CTRL, 32'h0); `CHK(pad_pullup, 8'hF0)
    wr(OFS_PORT_DIR, 32'hFF, 4'h0); rdr(OFS_PORT_DIR); `CHK(rd, 32'h0)
    wr(OFS_PORT_DIR, 32'h3C);
    `CHK({pad_oe, pad_out, pad_pullup}, 24'h3CF0C0)
    repeat (2) @(posedge mclk);
    rdr(OFS_PORT_IN); `CHK(rd, 32'hF1)
    wr(OFS_PORT_IN, 32'h11); rdr(OFS_PORT_OUT_VAL); `CHK(rd, 32'hE1)
    `CHK(pad_pullup, 8'hC1)
    rdr(OFS_PORT_IN); `CHK(rd, 32'hE1)
    wr(8'h10, 32'hFF); `CHK(rs, RESP_SLVERR)
    rdr(8'h10); `CHK({rd, rs}, {32'h0, RESP_SLVERR})
    rdr(OFS_PORT_DIR); `CHK({rd, rs}, {32'h3C, RESP_OKAY})
    @(posedge mclk) ext_val <= 8'h03;
    rdr(OFS_PORT_IN); `CHK(rd, 32'hE3)
    @(posedge mclk) begin sleep_clamp <= 1; ext_int_en <= 8'h02; end
    repeat (2) @(posedge mclk);
    rdr(OFS_PORT_IN); `CHK(rd, 32'h02)
    @(posedge mclk) sleep_clamp <= 0;
    repeat (2) @(posedge mclk);
    rdr(OFS_PORT_IN); `CHK(rd, 32'hE3)
    @(posedge mclk) resetn <= 0;
    #5 `CHK({pad_oe, pad_out, pad_pullup}, 24'h0)
    @(posedge mclk) resetn <= 1;
    rdr(OFS_PORT_OUT_VAL); `CHK(rd, 32'h0)
    wrap_up();
  end
endmodule : general_digital_io_port_pin_tb
